// *** logic/fifo_flag_modes.v ***
// fifo with standard and fall-through flag timing, offsets over apb
//
// The implementer's own choices: the register offsets and register access over APB.
`timescale 1ns/1ns
`include "fifo_flags_defines.vh"
module fifo_flag_modes (
  // apb clock and reset
  input wire pclk,
  input wire presetn,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`APB_ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output reg pslverr,
  // configuration pins, asynchronous to pclk
  input wire master_reset_n,
  input wire fall_through_select,
  input wire partial_flag_timing_select,
  // write side
  input wire write_enable_n,
  input wire [`DATA_W-1:0] data_in,
  // read side
  input wire read_enable_n,
  output wire [`DATA_W-1:0] data_out,
  // standard mode flags
  output wire empty_flag_n,
  output wire full_flag_n,
  // fall-through mode flags
  output wire output_ready_n,
  output wire input_space_n,
  // flags common to both modes
  output wire almost_empty_n,
  output wire almost_full_n,
  output wire half_full_n
);

  // binary to gray
  function [`PTR_W-1:0] bin2gray;
    input [`PTR_W-1:0] bin;
    begin
      bin2gray = bin ^ (bin >> 1);
    end
  endfunction

  // gray to binary, prefix xor from the top bit down
  function [`PTR_W-1:0] gray2bin;
    input [`PTR_W-1:0] gray;
    integer i;
    begin
      gray2bin[`PTR_W-1] = gray[`PTR_W-1];
      for (i = `PTR_W-2; i >= 0; i = i - 1) begin
        gray2bin[i] = gray2bin[i+1] ^ gray[i];
      end
    end
  endfunction

  // apb address decode, shared by read and write paths
  function addr_mapped;
    input [`APB_ADDR_W-1:0] addr;
    begin
      addr_mapped = (addr == `REG_CONFIG) || (addr == `REG_EMPTY_OFFSET) ||
                    (addr == `REG_FULL_OFFSET) || (addr == `REG_STATUS);
    end
  endfunction

  // synchronised configuration pins
  wire [2:0] pins_sync;
  wire in_reset;
  wire ft_pin;
  wire pf_pin;

  // mode and offsets
  reg ft_mode;
  reg pf_sync_mode;
  reg [`OFFSET_W-1:0] empty_offset;
  reg [`OFFSET_W-1:0] full_offset;

  // write side state
  reg [`PTR_W-1:0] wptr;
  reg [`PTR_W-1:0] wgray;
  wire [`PTR_W-1:0] rgray_at_w;
  wire [`PTR_W-1:0] rptr_at_w;
  wire [`PTR_W-1:0] wcount;
  wire [`PTR_W-1:0] next_wptr;
  wire wr_full;
  wire wr_do;

  // read side state
  reg [`PTR_W-1:0] rptr;
  reg [`PTR_W-1:0] rgray;
  reg out_valid;
  wire [`PTR_W-1:0] wgray_at_r;
  wire [`PTR_W-1:0] wptr_at_r;
  wire [`PTR_W-1:0] rcount;
  wire [`PTR_W-1:0] next_rptr;
  wire mem_empty;
  wire consume;
  wire fetch;

  // partial flag thresholds and state
  wire [`PTR_W-1:0] ae_level;
  wire [`PTR_W-1:0] af_level;
  wire [`PTR_W-1:0] raw_count;
  reg ae_sync_n;
  reg af_sync_n;
  wire ae_raw_n;
  wire af_raw_n;

  // apb decode
  wire apb_setup;
  wire apb_write;
  reg [31:0] read_value;

  // pins come from outside pclk, so they pass two flops first
  bit_sync #(
    .WIDTH(3)
  ) pin_sync (
    .clk(pclk),
    .rst_n(presetn),
    .async_in({master_reset_n, fall_through_select, partial_flag_timing_select}),
    .sync_out(pins_sync)
  );

  // synchronised reset value 0 means the fifo starts in master reset
  assign in_reset = ~pins_sync[2];
  assign ft_pin = pins_sync[1];
  assign pf_pin = pins_sync[0];

  // mode straps caught on clock edges while master reset is held
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ft_mode <= 1'b0;
      pf_sync_mode <= 1'b0;
    end else if (in_reset) begin
      ft_mode <= ft_pin;
      pf_sync_mode <= pf_pin;
    end
  end

  // write pointer, full when the memory proper holds depth words
  assign next_wptr = wptr + `PTR_ONE;
  assign rptr_at_w = gray2bin(rgray_at_w);
  assign wcount = wptr - rptr_at_w;
  assign wr_full = (wcount == `DEPTH);
  assign wr_do = ~write_enable_n & ~wr_full & ~in_reset;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wptr <= `PTR_ZERO;
      wgray <= `PTR_ZERO;
    end else if (in_reset) begin
      wptr <= `PTR_ZERO;
      wgray <= `PTR_ZERO;
    end else if (wr_do) begin
      wptr <= next_wptr;
      wgray <= bin2gray(next_wptr);
    end
  end

  // read pointer seen by the write side through two flops
  bit_sync #(
    .WIDTH(`PTR_W)
  ) rptr_sync (
    .clk(pclk),
    .rst_n(presetn),
    .async_in(rgray),
    .sync_out(rgray_at_w)
  );

  // write pointer seen by the read side through two flops
  bit_sync #(
    .WIDTH(`PTR_W)
  ) wptr_sync (
    .clk(pclk),
    .rst_n(presetn),
    .async_in(wgray),
    .sync_out(wgray_at_r)
  );

  // read side counts only words still in the memory, not the output register
  assign wptr_at_r = gray2bin(wgray_at_r);
  assign rcount = wptr_at_r - rptr;
  assign mem_empty = (rcount == `PTR_ZERO);
  assign next_rptr = rptr + `PTR_ONE;

  // fall-through fetches on its own to keep the output register full;
  // standard mode only moves on a request, and a request when empty is dropped
  assign consume = ~read_enable_n & out_valid;
  assign fetch = ~in_reset & ~mem_empty &
                 (ft_mode ? (~out_valid | consume) : ~read_enable_n);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rptr <= `PTR_ZERO;
      rgray <= `PTR_ZERO;
    end else if (in_reset) begin
      rptr <= `PTR_ZERO;
      rgray <= `PTR_ZERO;
    end else if (fetch) begin
      rptr <= next_rptr;
      rgray <= bin2gray(next_rptr);
    end
  end

  // output word held: this is the third stage behind the two sync flops
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_valid <= 1'b0;
    end else if (in_reset || !ft_mode) begin
      out_valid <= 1'b0;
    end else if (fetch) begin
      out_valid <= 1'b1;
    end else if (consume) begin
      out_valid <= 1'b0;
    end
  end

  // the store's read register is the data output in both modes
  fifo_store store (
    .clk(pclk),
    .rst_n(presetn),
    .wr_en(wr_do),
    .wr_addr(wptr[`ADDR_W-1:0]),
    .wr_data(data_in),
    .rd_en(fetch),
    .rd_addr(rptr[`ADDR_W-1:0]),
    .rd_data(data_out)
  );

  // thresholds work on the memory count in both modes: in fall-through the
  // output register adds the extra word, which shifts every flag by one
  assign ae_level = {1'b0, empty_offset} + `PTR_ONE;
  assign af_level = `DEPTH - {1'b0, full_offset};

  // asynchronous partial flags use the raw pointers; single clock, so no tearing
  assign raw_count = wptr - rptr;
  assign ae_raw_n = (raw_count >= ae_level);
  assign af_raw_n = ~(raw_count >= af_level);

  // synchronous partial flags: almost-full from the write view, almost-empty from the read view
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ae_sync_n <= 1'b0;
      af_sync_n <= 1'b1;
    end else if (in_reset) begin
      ae_sync_n <= 1'b0;
      af_sync_n <= 1'b1;
    end else begin
      ae_sync_n <= (rcount >= ae_level);
      af_sync_n <= ~(wcount >= af_level);
    end
  end

  assign almost_empty_n = pf_sync_mode ? ae_sync_n : ae_raw_n;
  assign almost_full_n = pf_sync_mode ? af_sync_n : af_raw_n;

  // half-full from the write view; memory count makes fall-through one word later
  assign half_full_n = ~(wcount > `HALF_DEPTH);

  // mode flags; the pair of the other mode stays high
  assign empty_flag_n = ft_mode ? 1'b1 : ~mem_empty;
  assign full_flag_n = ft_mode ? 1'b1 : ~wr_full;
  assign output_ready_n = ft_mode ? ~out_valid : 1'b1;
  assign input_space_n = ft_mode ? wr_full : 1'b1;

  // zero wait states: every access completes in its first access cycle
  assign pready = 1'b1;
  assign apb_setup = psel & ~penable;
  assign apb_write = psel & penable & pwrite & addr_mapped(paddr);

  // offset registers; master reset restores the defaults and wins over a write
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      empty_offset <= `OFFSET_DEFAULT;
      full_offset <= `OFFSET_DEFAULT;
    end else if (in_reset) begin
      empty_offset <= `OFFSET_DEFAULT;
      full_offset <= `OFFSET_DEFAULT;
    end else if (apb_write) begin
      if (paddr == `REG_EMPTY_OFFSET) begin
        empty_offset <= pwdata[`OFFSET_W-1:0];
      end
      if (paddr == `REG_FULL_OFFSET) begin
        full_offset <= pwdata[`OFFSET_W-1:0];
      end
    end
  end

  // read mux; unmapped addresses read zero
  always @* begin
    read_value = 32'h00000000;
    case (paddr)
      `REG_CONFIG: begin
        read_value[`CFG_FT_BIT] = ft_mode;
        read_value[`CFG_PF_BIT] = pf_sync_mode;
      end
      `REG_EMPTY_OFFSET: begin
        read_value[`OFFSET_W-1:0] = empty_offset;
      end
      `REG_FULL_OFFSET: begin
        read_value[`OFFSET_W-1:0] = full_offset;
      end
      `REG_STATUS: begin
        read_value = {`STAT_PAD, almost_empty_n, almost_full_n, half_full_n,
                      ~mem_empty, ~wr_full, out_valid, wcount};
      end
      default: begin
        read_value = 32'h00000000;
      end
    endcase
  end

  // read data and error captured in setup so they come from flops in access
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (apb_setup) begin
      prdata <= read_value;
      pslverr <= ~addr_mapped(paddr);
    end
  end

endmodule // fifo_flag_modes

// *** common/fifo_flags_defines.vh ***
// shared widths, depth, register map and reset values for the flag-mode fifo
`ifndef FIFO_FLAGS_DEFINES_VH
`define FIFO_FLAGS_DEFINES_VH

// storage geometry
`define DATA_W 72
`define ADDR_W 14
`define PTR_W 15
`define OFFSET_W 14
`define DEPTH 15'h4000
`define HALF_DEPTH 15'h2000
`define PTR_ONE 15'h0001
`define PTR_ZERO 15'h0000

// offsets loaded at reset and at every master reset
`define OFFSET_DEFAULT 14'h007F

// apb register byte addresses
`define APB_ADDR_W 12
`define REG_CONFIG 12'h000
`define REG_EMPTY_OFFSET 12'h004
`define REG_FULL_OFFSET 12'h008
`define REG_STATUS 12'h00C

// config register fields
`define CFG_FT_BIT 0
`define CFG_PF_BIT 1

// status register layout: count, output word held, five flags
`define STAT_PAD_W 11
`define STAT_PAD 11'h000

`endif

// *** logic/bit_sync.v ***
// two-flop synchroniser for levels and gray-coded words
`timescale 1ns/1ns
module bit_sync #(
  parameter WIDTH = 1
) (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // level in, synchronised level out
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] stage1;

  // stage1 is read by the second flop only, to keep metastability contained
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1 <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end

endmodule // bit_sync

// *** logic/fifo_store.v ***
// fifo word store with one write port and a registered read port
`timescale 1ns/1ns
`include "fifo_flags_defines.vh"
module fifo_store (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // write port
  input wire wr_en,
  input wire [`ADDR_W-1:0] wr_addr,
  input wire [`DATA_W-1:0] wr_data,
  // read port, data valid the edge after rd_en
  input wire rd_en,
  input wire [`ADDR_W-1:0] rd_addr,
  output reg [`DATA_W-1:0] rd_data
);

  reg [`DATA_W-1:0] cells [0:(1<<`ADDR_W)-1];

  // array itself is not reset; only the output register is
  always @(posedge clk) begin
    if (wr_en) begin
      cells[wr_addr] <= wr_data;
    end
  end

  // read data holds until the next read, so it doubles as the output register
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= {`DATA_W{1'b0}};
    end else if (rd_en) begin
      rd_data <= cells[rd_addr];
    end
  end

endmodule // fifo_store

// *** bench/fifo_flag_modes_monitor.sv ***
// port checker for the flag-mode fifo
`timescale 1ns/1ns
`include "fifo_flags_defines.vh"
module fifo_flag_modes_monitor (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // apb
  input wire psel,
  input wire penable,
  input wire pready,
  // pins
  input wire master_reset_n,
  input wire fall_through_select,
  input wire write_enable_n,
  input wire read_enable_n,
  input wire [`DATA_W-1:0] data_out,
  // flags
  input wire empty_flag_n,
  input wire full_flag_n,
  input wire output_ready_n,
  input wire input_space_n,
  input wire half_full_n,
  input wire almost_full_n
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic ft;
  logic [3:0] mr_hist;
  logic quiet;
  // mode strap as seen in master reset; quiet keeps mode switches out of view
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ft <= 1'b0;
      mr_hist <= 4'h0;
    end else begin
      mr_hist <= {mr_hist[2:0], master_reset_n};
      if (!master_reset_n) ft <= fall_through_select;
    end
  end
  assign quiet = master_reset_n && (&mr_hist);
  a_apb_no_wait: assert property (psel && penable |-> pready) else $error("apb waited");
  a_std_pair_idle: assert property (quiet && (!empty_flag_n || !full_flag_n) |-> output_ready_n && input_space_n)
    else $error("both flag pairs active");
  a_ft_pair_idle: assert property (quiet && (!output_ready_n || !input_space_n) |-> empty_flag_n && full_flag_n)
    else $error("both flag pairs active");
  a_empty_two_stage: assert property (quiet && !write_enable_n && $past(write_enable_n) &&
    $past(write_enable_n, 2) && !empty_flag_n |=> !empty_flag_n [*2] ##1 empty_flag_n) else $error("empty flag timing");
  a_ft_fall_three: assert property (quiet && ft && !write_enable_n && $past(write_enable_n) &&
    $past(write_enable_n, 2) && $past(write_enable_n, 3) && output_ready_n
    |=> output_ready_n [*3] ##1 !output_ready_n) else $error("first word timing");
  a_full_holds: assert property (quiet && !full_flag_n && read_enable_n && $past(read_enable_n) &&
    $past(read_enable_n, 2) && $past(read_enable_n, 3) |=> !full_flag_n) else $error("full flag left");
  a_full_half: assert property (!full_flag_n |-> !half_full_n) else $error("full without half");
  a_empty_half: assert property (!empty_flag_n |-> half_full_n) else $error("empty with half");
  a_data_hold: assert property (quiet && !ft && read_enable_n |=> $stable(data_out))
    else $error("data out moved");
  // main scenarios reached
  c_full: cover property (!full_flag_n);
  c_ready: cover property ($fell(output_ready_n));
  c_almost_full: cover property ($fell(almost_full_n));
endmodule // fifo_flag_modes_monitor
bind fifo_flag_modes fifo_flag_modes_monitor fifo_flag_modes_monitor_i (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pready(pready), .master_reset_n(master_reset_n),
  .fall_through_select(fall_through_select), .write_enable_n(write_enable_n), .read_enable_n(read_enable_n),
  .data_out(data_out), .empty_flag_n(empty_flag_n), .full_flag_n(full_flag_n), .output_ready_n(output_ready_n),
  .input_space_n(input_space_n), .half_full_n(half_full_n), .almost_full_n(almost_full_n));

// *** bench/fifo_far_side.sv ***
// writer and reader model on the far side of the fifo
`timescale 1ns/1ns
`include "fifo_flags_defines.vh"
module fifo_far_side (
  // clock
  input wire pclk,
  // writer
  output logic write_enable_n,
  output logic [`DATA_W-1:0] data_in,
  // reader
  output logic read_enable_n
);
  int wcnt = 0;
  // idle levels from time zero
  initial begin
    write_enable_n = 1'b1;
    read_enable_n = 1'b1;
    data_in = '0;
  end
  // numbered word; the multiplied copy makes its 32 middle data bits toggle over a run
  function automatic logic [`DATA_W-1:0] word(input int n);
    word = {8'(n), 32'(n) * 32'h9E3779B1, 32'(n)};
  endfunction
  // one numbered word per edge; released data is inverted so it never looks valid
  task automatic push(input int n);
    @(posedge pclk);
    repeat (n) begin
      write_enable_n <= 1'b0;
      data_in <= word(wcnt);
      wcnt++;
      @(posedge pclk);
    end
    write_enable_n <= 1'b1;
    data_in <= ~data_in;
  endtask
  // every word asked for with its own read edge
  task automatic pop(input int n);
    @(posedge pclk);
    read_enable_n <= 1'b0;
    repeat (n) @(posedge pclk);
    read_enable_n <= 1'b1;
  endtask
endmodule // fifo_far_side

// *** bench/dual_clock_fifo_flag_modes_bench.sv ***
// self-checking bench for the flag-mode fifo
`timescale 1ns/1ns
`include "fifo_flags_defines.vh"
`define chk(a, b) begin checks++; if ((a) !== (b)) begin error_cnt++; $display("unexpected %0t mismatch", $time); end end
module dual_clock_fifo_flag_modes_bench;
  logic pclk, presetn, psel, penable, pwrite, master_reset_n, fall_through_select, partial_flag_timing_select;
  logic [11:0] paddr;
  logic [31:0] pwdata, rd;
  logic err;
  wire [31:0] prdata;
  wire pready, pslverr, write_enable_n, read_enable_n, empty_flag_n, full_flag_n, output_ready_n, input_space_n;
  wire almost_empty_n, almost_full_n, half_full_n;
  wire [`DATA_W-1:0] data_in, data_out;
  int error_cnt = 0;
  int checks = 0;
  fifo_flag_modes fifo_flag_modes_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .master_reset_n(master_reset_n), .fall_through_select(fall_through_select),
    .partial_flag_timing_select(partial_flag_timing_select), .write_enable_n(write_enable_n), .data_in(data_in),
    .read_enable_n(read_enable_n), .data_out(data_out), .empty_flag_n(empty_flag_n), .full_flag_n(full_flag_n),
    .output_ready_n(output_ready_n), .input_space_n(input_space_n), .almost_empty_n(almost_empty_n),
    .almost_full_n(almost_full_n), .half_full_n(half_full_n));
  fifo_far_side u (.pclk(pclk), .write_enable_n(write_enable_n), .data_in(data_in), .read_enable_n(read_enable_n));
  // 125 MHz clock
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // one apb transfer; the answer is taken at the edge that sees pready
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50) begin
      n++;
      @(posedge pclk);
    end
    // a slave that never answers counts against the run
    if (n >= 50) begin
      error_cnt++;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // master reset with steady straps, then the settling edges
  task automatic mode(input logic ft, input logic pf);
    @(posedge pclk);
    fall_through_select <= ft;
    partial_flag_timing_select <= pf;
    master_reset_n <= 1'b0;
    repeat (4) @(posedge pclk);
    master_reset_n <= 1'b1;
    repeat (4) @(posedge pclk);
  endtask
  // let flags cross the two synchronising stages
  task automatic settle;
    repeat (5) @(posedge pclk);
    #1;
  endtask
  task automatic results;
    if (error_cnt == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    master_reset_n = 0; fall_through_select = 0; partial_flag_timing_select = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    // standard mode, offsets n=3 m=5
    mode(1'b0, 1'b0);
    apb(0, `REG_CONFIG, 0); `chk(rd, 32'h0)
    apb(1, `REG_EMPTY_OFFSET, 32'hFFFFFFFF);
    apb(0, `REG_EMPTY_OFFSET, 0); `chk(rd, 32'h00003FFF)
    `chk(err, 1'b0)
    apb(1, `REG_EMPTY_OFFSET, 3);
    apb(1, `REG_FULL_OFFSET, 5);
    apb(0, `REG_EMPTY_OFFSET, 0); `chk(rd, 32'h3)
    apb(0, `REG_FULL_OFFSET, 0); `chk(rd, 32'h5)
    apb(0, 12'hFF3, 0); `chk(err, 1'b1)
    `chk(rd, 32'h0)
    `chk(empty_flag_n, 1'b0)
    u.push(1); settle; `chk(empty_flag_n, 1'b1)
    u.push(2); settle; `chk(almost_empty_n, 1'b0)
    u.push(1); settle; `chk(almost_empty_n, 1'b1)
    u.push(8188); settle; `chk(half_full_n, 1'b1)
    u.push(1); settle; `chk(half_full_n, 1'b0)
    u.push(8185); settle; `chk(almost_full_n, 1'b1)
    u.push(1); settle; `chk(almost_full_n, 1'b0)
    u.push(5); settle; `chk(full_flag_n, 1'b0)
    apb(0, `REG_STATUS, 0); `chk(rd, 32'h00124000)
    u.push(1);
    u.pop(1); settle; `chk(full_flag_n, 1'b1)
    `chk(data_out, u.word(0))
    u.pop(16379); settle; `chk(almost_empty_n, 1'b1)
    u.pop(1); settle; `chk(almost_empty_n, 1'b0)
    u.pop(5); settle; `chk(empty_flag_n, 1'b0)
    `chk(data_out, u.word(16383))
    // fall-through mode, offsets back at 127
    mode(1'b1, 1'b1);
    apb(0, `REG_CONFIG, 0); `chk(rd, 32'h3)
    u.push(1);
    repeat (3) @(posedge pclk);
    #1; `chk(output_ready_n, 1'b0)
    `chk(data_out, u.word(16385))
    u.push(127); settle; `chk(almost_empty_n, 1'b0)
    u.push(1); settle; `chk(almost_empty_n, 1'b1)
    u.push(8064); settle; `chk(half_full_n, 1'b1)
    u.push(1); settle; `chk(half_full_n, 1'b0)
    u.push(8063); settle; `chk(almost_full_n, 1'b1)
    u.push(1); settle; `chk(almost_full_n, 1'b0)
    u.push(126); settle; `chk(input_space_n, 1'b0)
    u.push(1); settle; `chk(input_space_n, 1'b1)
    apb(0, `REG_STATUS, 0); `chk(rd, 32'h0012C000)
    u.push(1);
    u.pop(1); settle; `chk(input_space_n, 1'b0)
    u.pop(16383); settle; `chk(data_out, u.word(32769))
    u.pop(2); settle; `chk(output_ready_n, 1'b1)
    results;
  end
  // hang guard well past the planned run
  initial begin
    #700000;
    error_cnt++;
    results;
  end
endmodule // dual_clock_fifo_flag_modes_bench
